// *** design/sfrp_host.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "sfrp_defines.svh"

// Host-side serial flash controller: frames reads, burst set-up and page program
module sfrp_host import sfrp_pkg::*; #(
	parameter logic [7:0] WRITE_ENABLE_OPCODE = 8'h06
) (
	input  wire logic        core_clk_i,
	input  wire logic        reset_i,
	input  wire logic        cmd_valid_i,
	input  wire logic [3:0]  cmd_i,
	input  wire logic        quad_command_mode_i,
	input  wire logic [23:0] addr_i,
	input  wire logic [15:0] len_i,
	input  wire logic [7:0]  param_byte_i,
	input  wire logic        abort_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wdata_valid_i,
	input  wire logic [3:0]  dq_i,
	output var  logic        cmd_ready_o,
	output var  logic        wdata_ready_o,
	output var  logic [7:0]  rdata_o,
	output var  logic        rdata_valid_o,
	output var  logic        done_o,
	output var  logic        cont_mode_o,
	output var  logic [7:0]  burst_len_o,
	output var  logic        sclk_o,
	output var  logic        cs_n_o,
	output var  logic [3:0]  dq_o,
	output var  logic [3:0]  dq_oe_o
);

	localparam logic [7:0] HALF_M1 = 8'(`SFRP_SCLK_HALF_CYC - 1);
	localparam logic [7:0] GAP_M1  = 8'(`SFRP_CS_IDLE_CYC - 1);

	sfrp_state_e state;
	sfrp_phase_e ph;
	sfrp_phase_e next_ph;
	sfrp_cmd_e   cmd;
	logic        quad_cmd;
	logic [23:0] addr;
	logic [7:0]  pbyte;
	logic [15:0] byte_left;
	logic [15:0] fetch_left;
	logic        endless;
	logic [7:0]  div_cnt;
	logic [7:0]  clk_left;
	logic [31:0] tx_sr;
	logic [7:0]  rx_sr;
	logic [3:0]  rx_cnt;
	logic [7:0]  wbuf;
	logic        have;
	logic [3:0]  dq_s;
	logic [2:0]  cur_l;
	logic [31:0] ld_tx;
	logic [31:0] sh_tx;
	logic [7:0]  ld_clks;
	logic        drive;
	logic [7:0]  rx_next;
	logic        rx_full;
	logic        wr_stall;
	logic        tick;
	logic        fin;
	logic        take;
	logic        next_have;
	logic [15:0] next_fetch;

	// Line sampling through two flops before any decision reads it
	sfrp_sync #(.WIDTH(4)) u_dq_sync (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.async_i    (dq_i),
		.sync_o     (dq_s)
	);

	function automatic logic [7:0] opcode_of(input sfrp_cmd_e c);
		case (c)
			SFRP_CMD_DUAL_RD:                    return `SFRP_OP_DUAL_RD;
			SFRP_CMD_QUAD_RD, SFRP_CMD_QCONT_RD: return `SFRP_OP_QUAD_RD;
			SFRP_CMD_SET_BURST:                  return `SFRP_OP_SET_BURST;
			SFRP_CMD_BURST_RD:                   return `SFRP_OP_BURST_RD;
			SFRP_CMD_PROG:                       return `SFRP_OP_PROG;
			SFRP_CMD_WRITE_EN:                   return WRITE_ENABLE_OPCODE;
			default:                             return `SFRP_OP_CONT_EXIT;
		endcase
	endfunction : opcode_of

	// Lines per clock: opcode follows quad command mode, dual and quad read fields follow the command, all other fields follow quad command mode
	function automatic logic [2:0] lanes_of(input sfrp_cmd_e c, input sfrp_phase_e p,
		input logic q);
		if (p == SFRP_PH_OP)
			return q ? 3'h4 : 3'h1;  // [RL12]
		if (c == SFRP_CMD_DUAL_RD)
			return 3'h2;  // [RL1]
		if (c == SFRP_CMD_QUAD_RD || c == SFRP_CMD_QCONT_RD)
			return 3'h4;  // [RL3]
		return q ? 3'h4 : 3'h1;  // [RL12]
	endfunction : lanes_of

	function automatic logic [7:0] clks_for(input logic [7:0] bits, input logic [2:0] l);
		case (l)
			3'h2:    return bits >> 1;
			3'h4:    return bits >> 2;
			default: return bits;
		endcase
	endfunction : clks_for

	function automatic logic [3:0] pins_of(input logic [31:0] t, input logic [2:0] l);
		case (l)
			3'h2:    return {2'h0, t[31:30]};
			3'h4:    return t[31:28];
			default: return {3'h0, t[31]};
		endcase
	endfunction : pins_of

	function automatic logic [3:0] mask_of(input logic [2:0] l);
		case (l)
			3'h2:    return 4'h3;
			3'h4:    return 4'hF;
			default: return 4'h1;
		endcase
	endfunction : mask_of

	// Phase order of each frame kind
	always_comb begin
		next_ph = SFRP_PH_DONE;
		unique case (ph)
			SFRP_PH_OP: begin
				if (cmd == SFRP_CMD_SET_BURST)
					next_ph = SFRP_PH_WR;  // [RL10]
				else if (cmd != SFRP_CMD_WRITE_EN && cmd != SFRP_CMD_CONT_EXIT)
					next_ph = SFRP_PH_ADDR;
			end
			SFRP_PH_ADDR: begin
				if (cmd == SFRP_CMD_QCONT_RD)
					next_ph = SFRP_PH_MODE;  // [RL5]
				else if (cmd == SFRP_CMD_PROG)
					next_ph = SFRP_PH_WR;  // [RL16]
				else
					next_ph = SFRP_PH_DUMMY;
			end
			SFRP_PH_MODE:  next_ph = SFRP_PH_DUMMY;
			SFRP_PH_DUMMY: next_ph = SFRP_PH_RD;
			default:       next_ph = SFRP_PH_DONE;
		endcase
	end

	// Shift word and clock count for the phase about to start
	always_comb begin
		cur_l    = lanes_of(cmd, ph, quad_cmd);
		ld_tx    = 32'h0000_0000;
		ld_clks  = clks_for(`SFRP_OPCODE_BITS, cur_l);
		drive    = 1'b0;
		wr_stall = (ph == SFRP_PH_WR) && (cmd == SFRP_CMD_PROG) && !have;
		unique case (ph)
			SFRP_PH_OP: begin
				ld_tx = {opcode_of(cmd), 24'h00_0000};
				drive = 1'b1;
			end
			SFRP_PH_ADDR: begin
				ld_tx   = {addr, 8'h00};
				ld_clks = clks_for(`SFRP_ADDR_BITS, cur_l);
				drive   = 1'b1;
			end
			SFRP_PH_MODE: begin
				ld_tx   = {pbyte, 24'h00_0000};
				ld_clks = `SFRP_MODE_CLK;  // [RL5]
				drive   = 1'b1;
			end
			SFRP_PH_DUMMY: begin
				case (cmd)
					SFRP_CMD_DUAL_RD:  ld_clks = `SFRP_DUAL_DUMMY_CLK;
					SFRP_CMD_QUAD_RD:  ld_clks = `SFRP_QUAD_DUMMY_CLK;  // [RL3]
					SFRP_CMD_QCONT_RD: ld_clks = `SFRP_CONT_DUMMY_CLK;  // [RL5]
					default:           ld_clks = `SFRP_BURST_DUMMY_CLK;  // [RL13]
				endcase
			end
			SFRP_PH_WR: begin
				ld_tx = {(cmd == SFRP_CMD_SET_BURST) ? pbyte : wbuf, 24'h00_0000};
				drive = 1'b1;
			end
			SFRP_PH_RD, SFRP_PH_DONE: ld_clks = clks_for(`SFRP_OPCODE_BITS, cur_l);
			default: ld_clks = 8'h01;
		endcase
		// Most significant bits leave first, so the upper nibble goes before the lower
		case (cur_l)
			3'h2:    sh_tx = {tx_sr[29:0], 2'h0};
			3'h4:    sh_tx = {tx_sr[27:0], 4'h0};  // [RL12]
			default: sh_tx = {tx_sr[30:0], 1'h0};
		endcase
	end

	// Read byte assembly from the synchronised lines
	always_comb begin
		case (cur_l)
			3'h2:    rx_next = {rx_sr[5:0], dq_s[1:0]};
			3'h4:    rx_next = {rx_sr[3:0], dq_s[3:0]};
			default: rx_next = {rx_sr[6:0], dq_s[1]};
		endcase
		rx_full = (rx_cnt + {1'b0, cur_l}) == 4'h8;
	end

	assign tick = (state == SFRP_ST_RUN) && (div_cnt == HALF_M1);
	assign fin  = (state == SFRP_ST_HOLD) && (div_cnt == HALF_M1);

	// Frame sequencer; the serial clock is divided down here, so it is no second domain
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state <= SFRP_ST_IDLE;
			ph <= SFRP_PH_OP;
			cmd <= SFRP_CMD_WRITE_EN;
			quad_cmd <= 1'b0;
			addr <= 24'h00_0000;
			pbyte <= 8'h00;
			byte_left <= 16'h0001;
			endless <= 1'b0;
			div_cnt <= 8'h00;
			clk_left <= 8'h01;
			tx_sr <= 32'h0000_0000;
			rx_sr <= 8'h00;
			rx_cnt <= 4'h0;
			cmd_ready_o <= 1'b1;
			rdata_o <= 8'h00;
			rdata_valid_o <= 1'b0;
			done_o <= 1'b0;
			sclk_o <= 1'b0;
			cs_n_o <= 1'b1;
			dq_o <= 4'h0;
			dq_oe_o <= 4'h0;
		end else begin
			rdata_valid_o <= 1'b0;
			done_o <= 1'b0;
			unique case (state)
				SFRP_ST_IDLE: begin
					if (cmd_valid_i) begin
						cmd <= sfrp_cmd_e'(cmd_i);
						quad_cmd <= quad_command_mode_i;
						addr <= addr_i;
						pbyte <= param_byte_i;
						byte_left <= (len_i == 16'h0000 || cmd_i == SFRP_CMD_SET_BURST) ?
							16'h0001 : len_i;
						endless <= (len_i == 16'h0000) && (cmd_i == SFRP_CMD_DUAL_RD ||
							cmd_i == SFRP_CMD_QUAD_RD || cmd_i == SFRP_CMD_QCONT_RD ||
							cmd_i == SFRP_CMD_BURST_RD);
						// Continuous mode skips the opcode on the next continuous read frame
						ph <= (cmd_i == SFRP_CMD_QCONT_RD && cont_mode_o) ?
							SFRP_PH_ADDR : SFRP_PH_OP;
						cs_n_o <= 1'b0;
						cmd_ready_o <= 1'b0;
						div_cnt <= 8'h00;
						state <= SFRP_ST_LOAD;
					end
				end
				SFRP_ST_LOAD: begin
					// A program frame waits here with the clock low until data arrives
					if (!wr_stall) begin
						tx_sr <= ld_tx;
						clk_left <= ld_clks;
						dq_o <= pins_of(ld_tx, cur_l);
						dq_oe_o <= drive ? mask_of(cur_l) : 4'h0;  // [RL1] [RL3]
						rx_cnt <= 4'h0;
						state <= SFRP_ST_RUN;
					end
				end
				SFRP_ST_RUN: begin
					div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
					if (tick && !sclk_o) begin
						// Rising edge: the device's data has had a half period to settle
						sclk_o <= 1'b1;
						if (ph == SFRP_PH_RD) begin
							rx_sr <= rx_next;
							rx_cnt <= rx_full ? 4'h0 : rx_cnt + {1'b0, cur_l};
							if (rx_full) begin
								rdata_o <= rx_next;
								rdata_valid_o <= 1'b1;
							end
						end
					end else if (tick) begin
						// Falling edge: next bits go out
						sclk_o <= 1'b0;
						if (ph == SFRP_PH_RD && abort_i) begin
							ph <= SFRP_PH_DONE;  // [RL4]
							dq_oe_o <= 4'h0;
							state <= SFRP_ST_HOLD;
						end else if (clk_left != 8'h01) begin
							clk_left <= clk_left - 8'h01;
							tx_sr <= sh_tx;
							dq_o <= pins_of(sh_tx, cur_l);
						end else if ((ph == SFRP_PH_WR || ph == SFRP_PH_RD) &&
							(endless || byte_left != 16'h0001)) begin
							if (!endless)
								byte_left <= byte_left - 16'h0001;
							state <= SFRP_ST_LOAD;
						end else begin
							// Only whole bytes end a frame, except a read frame cut by abort_i
							ph <= next_ph;  // [RL19]
							if (next_ph == SFRP_PH_DONE) begin
								dq_oe_o <= 4'h0;
								state <= SFRP_ST_HOLD;
							end else begin
								state <= SFRP_ST_LOAD;
							end
						end
					end
				end
				SFRP_ST_HOLD: begin
					div_cnt <= fin ? 8'h00 : div_cnt + 8'h01;
					if (fin) begin
						cs_n_o <= 1'b1;  // [RL4] [RL19]
						done_o <= 1'b1;
						state <= SFRP_ST_GAP;
					end
				end
				SFRP_ST_GAP: begin
					div_cnt <= div_cnt + 8'h01;
					if (div_cnt == GAP_M1) begin
						div_cnt <= 8'h00;
						cmd_ready_o <= 1'b1;
						state <= SFRP_ST_IDLE;
					end
				end
				default: state <= SFRP_ST_IDLE;
			endcase
		end
	end

	// Single-byte program data holding stage; back-pressure via wdata_ready_o
	assign take       = wdata_valid_i && wdata_ready_o;
	assign next_have  = take | (have & ~((state == SFRP_ST_LOAD) && wr_stall == 1'b0 &&
		ph == SFRP_PH_WR && cmd == SFRP_CMD_PROG));
	assign next_fetch = take ? fetch_left - 16'h0001 : fetch_left;

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			wbuf <= 8'h00;
			have <= 1'b0;
			fetch_left <= 16'h0000;
			wdata_ready_o <= 1'b0;
		end else begin
			if (take)
				wbuf <= wdata_i;
			have <= next_have;
			if (state == SFRP_ST_IDLE && cmd_valid_i)
				fetch_left <= (cmd_i != SFRP_CMD_PROG) ? 16'h0000 :
					(len_i == 16'h0000) ? 16'h0001 : len_i;
			else
				fetch_left <= next_fetch;
			wdata_ready_o <= !next_have && next_fetch != 16'h0000 &&
				state != SFRP_ST_IDLE;
		end
	end

	// Host mirror of continuous mode and burst length
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cont_mode_o <= 1'b0;
			burst_len_o <= `SFRP_BURST_LEN_RST;
		end else if (done_o) begin
			if (cmd == SFRP_CMD_QCONT_RD)
				cont_mode_o <= pbyte[7:4] == ~pbyte[3:0];
			else if (cmd == SFRP_CMD_CONT_EXIT)
				cont_mode_o <= 1'b0;  // [RL8]
			if (cmd == SFRP_CMD_SET_BURST)
				burst_len_o <= pbyte;  // [RL10]
		end
	end

	// Helper for assertions: a phase has just been loaded
	logic just_loaded;
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i)
			just_loaded <= 1'b0;
		else
			just_loaded <= (state == SFRP_ST_LOAD) && !wr_stall;
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	AST_DUAL_ADDR: assert property ( // [RL1]
		just_loaded && cmd == SFRP_CMD_DUAL_RD && ph == SFRP_PH_ADDR
		|-> dq_oe_o == 4'h3 && clk_left == 8'h0C)
		else $error("dual address not on two lines for twelve clocks");
	AST_QUAD_ADDR: assert property ( // [RL3]
		just_loaded && cmd == SFRP_CMD_QUAD_RD && ph == SFRP_PH_ADDR
		|-> dq_oe_o == 4'hF && clk_left == 8'h06)
		else $error("quad address not six nibble clocks");
	AST_QUAD_DUMMY: assert property ( // [RL3]
		just_loaded && cmd == SFRP_CMD_QUAD_RD && ph == SFRP_PH_DUMMY
		|-> dq_oe_o == 4'h0 && clk_left == 8'h06)
		else $error("quad read dummy is not six released clocks");
	AST_ABORT_END: assert property ( // [RL4]
		tick && sclk_o && ph == SFRP_PH_RD && abort_i
		|=> dq_oe_o == 4'h0 ##[1:16] $rose(cs_n_o))
		else $error("abort did not end the read frame");
	AST_CONT_DUMMY: assert property ( // [RL5]
		just_loaded && cmd == SFRP_CMD_QCONT_RD && ph == SFRP_PH_DUMMY
		|-> clk_left == 8'h04 && $past(ph, 3) != SFRP_PH_DUMMY)
		else $error("continuous read dummy is not four clocks");
	AST_EXIT_CLEAR: assert property ( // [RL8]
		done_o && cmd == SFRP_CMD_CONT_EXIT |=> !cont_mode_o)
		else $error("exit frame left continuous mode set");
	AST_SET_BURST: assert property ( // [RL10]
		done_o && cmd == SFRP_CMD_SET_BURST |=> burst_len_o == $past(pbyte))
		else $error("burst length not stored");
	AST_QUAD_OPCODE: assert property ( // [RL12]
		just_loaded && quad_cmd && ph == SFRP_PH_OP
		|-> clk_left == 8'h02 && dq_o == tx_sr[31:28])
		else $error("quad command opcode not two nibbles upper first");
	AST_BURST_DUMMY: assert property ( // [RL13]
		just_loaded && cmd == SFRP_CMD_BURST_RD && ph == SFRP_PH_DUMMY |-> clk_left == 8'h08)
		else $error("burst read dummy is not eight clocks");
	AST_PROG_SELECT: assert property ( // [RL16]
		state == SFRP_ST_RUN && cmd == SFRP_CMD_PROG |-> !cs_n_o)
		else $error("select high during page program");
	AST_PROG_BOUNDARY: assert property ( // [RL19]
		$rose(cs_n_o) && cmd == SFRP_CMD_PROG |-> ph == SFRP_PH_DONE && !sclk_o)
		else $error("program frame ended off a byte boundary");

	COV_DUAL_DONE: cover property (done_o && cmd == SFRP_CMD_DUAL_RD);
	COV_CONT_SKIP: cover property (just_loaded && cmd == SFRP_CMD_QCONT_RD &&
		ph == SFRP_PH_ADDR && cont_mode_o);
	COV_PROG_DONE: cover property (done_o && cmd == SFRP_CMD_PROG);
	COV_ABORT: cover property (tick && sclk_o && ph == SFRP_PH_RD && abort_i);

endmodule : sfrp_host

`default_nettype wire

// *** design/sfrp_defines.svh ***
`ifndef SFRP_DEFINES_SVH
`define SFRP_DEFINES_SVH
// Notes on behaviour
// RL1 - Dual read: address, dummy, data on two lines
// RL2 - Device read address increments, wraps to zero
// RL3 - Quad read: opcode, nibble address, six dummies
// RL4 - Chip select may end quad read anytime
// RL5 - Continuous form: mode byte, four dummy clocks
// RL6 - Complementary mode nibbles keep opcode-less frames
// RL7 - Non-complementary mode byte cancels continuous mode
// RL8 - Lone FFh frame forces continuous mode exit
// RL9 - Device ignores quad read while busy
// RL10 - Set burst: opcode plus one length byte
// RL11 - Burst length resets to code 00h
// RL12 - Quad command mode: bytes as two nibbles
// RL13 - Burst read: opcode, address, eight dummy clocks
// RL14 - Device wraps burst inside aligned window
// RL15 - Program needs write enable latch set
// RL16 - Program: opcode, address, data, select low
// RL17 - Program address wraps within its page
// RL18 - Device keeps last 256 program bytes
// RL19 - Raise select only on a byte boundary
// RL20 - Program cycle sets then clears busy flag
// RL21 - Protected pages are never programmed
// RL22 - Burst codes 01h-03h mean 16-64 bytes
// RL23 - Mode state reset; lines released when deselected

// Opcodes
`define SFRP_OP_DUAL_RD     8'hBB
`define SFRP_OP_QUAD_RD     8'hEB
`define SFRP_OP_SET_BURST   8'hC0
`define SFRP_OP_BURST_RD    8'h0C
`define SFRP_OP_PROG        8'h02
`define SFRP_OP_CONT_EXIT   8'hFF

// Frame field sizes in bits
`define SFRP_OPCODE_BITS    8'h08
`define SFRP_ADDR_BITS      8'h18

// Dummy clocks after address (or mode byte), and the clocks of the mode byte
`define SFRP_DUAL_DUMMY_CLK  8'h04
`define SFRP_QUAD_DUMMY_CLK  8'h06
`define SFRP_CONT_DUMMY_CLK  8'h04
`define SFRP_BURST_DUMMY_CLK 8'h08
`define SFRP_MODE_CLK        8'h02

// Reset values
`define SFRP_BURST_LEN_RST  8'h00

// Timing
`define SFRP_CORE_PERIOD_NS 4
`define SFRP_SCLK_HALF_NS   16
`define SFRP_SCLK_HALF_CYC  ((`SFRP_SCLK_HALF_NS + `SFRP_CORE_PERIOD_NS - 1) / `SFRP_CORE_PERIOD_NS)
`define SFRP_CS_IDLE_NS     40
`define SFRP_CS_IDLE_CYC    ((`SFRP_CS_IDLE_NS + `SFRP_CORE_PERIOD_NS - 1) / `SFRP_CORE_PERIOD_NS)

`endif

// *** design/sfrp_pkg.sv ***
`default_nettype none

package sfrp_pkg;

	// User commands
	typedef enum logic [3:0] {
		SFRP_CMD_DUAL_RD   = 4'h0,
		SFRP_CMD_QUAD_RD   = 4'h1,
		SFRP_CMD_QCONT_RD  = 4'h2,
		SFRP_CMD_CONT_EXIT = 4'h3,
		SFRP_CMD_SET_BURST = 4'h4,
		SFRP_CMD_BURST_RD  = 4'h5,
		SFRP_CMD_PROG      = 4'h6,
		SFRP_CMD_WRITE_EN  = 4'h7
	} sfrp_cmd_e;

	// Frame sequencer states
	typedef enum logic [2:0] {
		SFRP_ST_IDLE = 3'b000,
		SFRP_ST_LOAD = 3'b001,
		SFRP_ST_RUN  = 3'b010,
		SFRP_ST_HOLD = 3'b011,
		SFRP_ST_GAP  = 3'b100
	} sfrp_state_e;

	// Frame phases
	typedef enum logic [2:0] {
		SFRP_PH_OP    = 3'b000,
		SFRP_PH_ADDR  = 3'b001,
		SFRP_PH_MODE  = 3'b010,
		SFRP_PH_DUMMY = 3'b011,
		SFRP_PH_WR    = 3'b100,
		SFRP_PH_RD    = 3'b101,
		SFRP_PH_DONE  = 3'b110
	} sfrp_phase_e;

endpackage : sfrp_pkg

`default_nettype wire

// *** design/sfrp_sync.sv ***
`timescale 1ns/1ns
`default_nettype none

// Two-stage synchroniser for pin inputs
module sfrp_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             core_clk_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] async_i,
	output var  logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			meta   <= '0;
			sync_o <= '0;
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end

endmodule : sfrp_sync

`default_nettype wire

// *** dv/sfrp_flash_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// Behavioural serial flash that decodes host frames on the pins and answers on the data lines
module sfrp_flash_model #(
	parameter int          PROG_NS   = 4000,
	parameter logic [7:0]  WE_OP     = 8'h06,
	parameter logic [23:0] PROT_BASE = 24'h03_0000
) (
	input  wire logic       sclk_i,
	input  wire logic       cs_n_i,
	input  wire logic       quad_mode_i,
	input  wire logic [3:0] dq_host_i,
	input  wire logic [3:0] dq_oe_i,
	output var  logic [3:0] dq_wire_o,
	output var  logic       busy_o
);
	logic [7:0]  mem [logic [23:0]];
	logic [7:0]  pb [256];
	logic        pm [256];
	logic [3:0]  dev_dq;
	logic [3:0]  dev_oe;
	logic [7:0]  op;
	logic [7:0]  blen;
	logic [7:0]  pa;
	logic [23:0] base;
	logic        we_latch;
	logic        cont;
	logic        cont0;
	logic        seen;
	int          nb;
	int          part;
	event        prog_ev;

	// Power-up state: shortest burst window, continuous mode off
	initial begin
		blen = 8'h00;
		cont = 1'b0;
		we_latch = 1'b0;
		busy_o = 1'b0;
		dev_dq = 4'h0;
		dev_oe = 4'h0;
	end

	// Released lines show the inverse of the last value, so a stale read cannot pass
	assign dq_wire_o = (dq_oe_i & dq_host_i) | (~dq_oe_i & dev_oe & dev_dq)
		| (~dq_oe_i & ~dev_oe & ~dev_dq);

	function automatic logic [7:0] at(input logic [23:0] a);
		logic [23:0] m;
		m = a & 24'h03_FFFF;
		return mem.exists(m) ? mem[m] : (m[7:0] ^ m[15:8] ^ {6'h00, m[17:16]});
	endfunction : at

	task automatic get(input int w, input int n, output logic [31:0] v);
		v = 32'h0000_0000;
		repeat (n) begin
			@(posedge sclk_i);
			v = (v << w) | (32'(dq_wire_o) & ((32'd1 << w) - 1));
		end
	endtask : get

	// Streams bytes on falling edges; a nonzero window size wraps inside that window
	task automatic send(input int w, input logic [23:0] a, input int ws);
		logic [7:0] t;
		seen = 1'b1;
		forever begin
			t = at(a);
			repeat (8 / w) begin
				@(negedge sclk_i);
				#2;
				dev_oe = (w == 1) ? 4'b0010 : (w == 2) ? 4'b0011 : 4'b1111;
				dev_dq = (w == 1) ? {2'b00, t[7], 1'b0} : 4'(t >> (8 - w));
				t = t << w;
			end
			if (ws != 0) a = (a & ~24'(ws - 1)) | ((a + 1) & 24'(ws - 1));
			else a = (a + 1) & 24'h03_FFFF;
		end
	endtask : send

	task automatic frame();
		logic [31:0] v;
		logic [23:0] a;
		logic [7:0]  acc;
		int          w;
		w = quad_mode_i ? 4 : 1;
		acc = 8'h00;
		if (busy_o) @(posedge cs_n_i);
		if (cont) v = 32'h0000_00EB;
		else get(w, 8 / w, v);
		op = v[7:0];
		case (op)
			8'hBB: begin
				get(2, 12, v);
				a = v[23:0];
				get(2, 4, v);
				send(2, a, 0);
			end
			8'hEB: begin
				get(4, 6, v);
				a = v[23:0];
				get(4, 2, v);
				cont = (v[7:4] == ~v[3:0]);
				get(4, 4, v);
				send(4, a, 0);
			end
			8'hC0: begin
				get(w, 8 / w, v);
				blen = v[7:0];
			end
			8'h0C: begin
				get(w, 24 / w, v);
				a = v[23:0];
				get(w, 8, v);
				send(w, a, 8 << blen[1:0]);
			end
			WE_OP: we_latch = 1'b1;
			8'h02: if (we_latch) begin
				get(w, 24 / w, v);
				base = v[23:0];
				pa = v[7:0];
				forever begin
					get(w, 1, v);
					acc = 8'((32'(acc) << w) | v);
					part++;
					if (part == 8 / w) begin
						pb[pa] = acc;
						pm[pa] = 1'b1;
						pa++;
						nb++;
						part = 0;
					end
				end
			end
			default: ;
		endcase
	endtask : frame

	// One frame per select-low period; select high cuts off whatever phase is running
	initial forever begin
		@(negedge cs_n_i);
		op = 8'h00;
		seen = 1'b0;
		nb = 0;
		part = 0;
		cont0 = cont;
		foreach (pm[i]) pm[i] = 1'b0;
		fork
			frame();
			@(posedge cs_n_i);
		join_any
		disable fork;
		dev_oe = 4'b0000;
		if (cont0 && !seen) cont = 1'b0;
		if (op == 8'h02 && nb > 0 && part == 0) -> prog_ev;
	end

	// Self-timed program cycle; the latch drops before the busy flag does
	always @(prog_ev) begin
		busy_o = 1'b1;
		#(PROG_NS / 2);
		we_latch = 1'b0;
		#(PROG_NS / 2);
		if ((base & 24'h03_FFFF) < PROT_BASE) begin
			foreach (pm[i]) if (pm[i]) mem[{6'h00, base[17:8], 8'(i)}] = pb[i];
		end
		busy_o = 1'b0;
	end
endmodule : sfrp_flash_model

`default_nettype wire

// *** dv/serial_flash_read_program_cmds_tb.sv ***
`timescale 1ns/1ns
`default_nettype none

`define SFRP_CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module serial_flash_read_program_cmds_tb import sfrp_pkg::*;;
	logic        core_clk_i, reset_i, cmd_valid_i, quad_command_mode_i, abort_i;
	logic        wdata_valid_i, cmd_ready_o, wdata_ready_o, rdata_valid_o, done_o;
	logic        cont_mode_o, sclk_o, cs_n_o, flash_busy;
	logic [3:0]  cmd_i, dq_i, dq_o, dq_oe_o;
	logic [23:0] addr_i;
	logic [15:0] len_i;
	logic [7:0]  param_byte_i, wdata_i, rdata_o, burst_len_o, exp_b;
	logic [7:0]  exp_q[$], wq[$], sh[logic [23:0]];
	logic [7:0]  modes [8] = '{8'hA5, 8'h5A, 8'hF0, 8'h0F, 8'hFF, 8'h00, 8'hAA, 8'h55};
	int          n_errors, check_count, seed, ws;

	sfrp_host dut_u (.core_clk_i, .reset_i, .cmd_valid_i, .cmd_i, .quad_command_mode_i,
		.addr_i, .len_i, .param_byte_i, .abort_i, .wdata_i, .wdata_valid_i, .dq_i,
		.cmd_ready_o, .wdata_ready_o, .rdata_o, .rdata_valid_o, .done_o, .cont_mode_o,
		.burst_len_o, .sclk_o, .cs_n_o, .dq_o, .dq_oe_o);

	sfrp_flash_model flash_u (.sclk_i(sclk_o), .cs_n_i(cs_n_o), .quad_mode_i(quad_command_mode_i),
		.dq_host_i(dq_o), .dq_oe_i(dq_oe_o), .dq_wire_o(dq_i), .busy_o(flash_busy));

	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end

	// Read bytes are matched in arrival order against the oldest expectation
	always @(posedge core_clk_i) if (rdata_valid_o === 1'b1) begin
		exp_b = (exp_q.size() != 0) ? exp_q.pop_front() : ~rdata_o;
		`SFRP_CHK(rdata_o, exp_b)
	end

	// Program data feeder; a byte leaves the queue only at an accepted edge
	always @(posedge core_clk_i) begin
		if (wdata_valid_i && wdata_ready_o) void'(wq.pop_front());
		#1;
		wdata_valid_i = (wq.size() != 0);
		wdata_i = (wq.size() != 0) ? wq[0] : 8'h00;
	end

	task automatic print_verdict();
		$display("checks=%0d errors=%0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	function automatic logic [7:0] exp_at(input logic [23:0] a);
		logic [23:0] m;
		m = a & 24'h03_FFFF;
		return sh.exists(m) ? sh[m] : (m[7:0] ^ m[15:8] ^ {6'h00, m[17:16]});
	endfunction : exp_at

	function automatic logic [23:0] rnd();
		return 24'($random(seed)) & 24'h03_FFFF;
	endfunction : rnd

	task automatic run(input logic [3:0] c, input logic [23:0] a, input logic [15:0] l,
		input logic [7:0] p, input logic q);
		int n;
		n = 0;
		while (cmd_ready_o !== 1'b1 && n < 2000) begin
			@(posedge core_clk_i);
			n++;
		end
		if (n >= 2000) n_errors++;
		#1;
		{cmd_valid_i, cmd_i, addr_i, len_i, param_byte_i, quad_command_mode_i} = {1'b1, c, a, l, p, q};
		@(posedge core_clk_i);
		#1 cmd_valid_i = 1'b0;
		n = 0;
		while (done_o !== 1'b1 && n < 30000) begin
			@(posedge core_clk_i);
			n++;
		end
		if (n >= 30000) begin
			n_errors++;
			print_verdict();
		end
		repeat (2) @(posedge core_clk_i);
	endtask : run

	// Window size zero means a linear read with wrap at the top of the array
	task automatic rd(input logic [3:0] c, input logic [23:0] a, input int n, input logic [7:0] p,
		input logic q, input int w);
		logic [23:0] x;
		x = a;
		repeat (n) begin
			exp_q.push_back(exp_at(x));
			x = (w != 0) ? ((x & ~24'(w - 1)) | ((x + 1) & 24'(w - 1))) : ((x + 1) & 24'h03_FFFF);
		end
		run(c, a, 16'(n), p, q);
		`SFRP_CHK(32'(exp_q.size()), 32'd0)
	endtask : rd

	task automatic prog(input logic [23:0] a, input int n, input logic ok, input logic q);
		logic [7:0] d;
		int         k;
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			wq.push_back(d);
			if (ok) sh[{6'h00, a[17:8], 8'(a[7:0] + i)}] = d;
		end
		run(SFRP_CMD_PROG, a, 16'(n), 8'h00, q);
		`SFRP_CHK(32'(wq.size()), 32'd0)
		k = 0;
		while (flash_busy !== 1'b0 && k < 3000) begin
			@(posedge core_clk_i);
			k++;
		end
		if (k >= 3000) n_errors++;
	endtask : prog

	initial begin
		#200_000;
		n_errors++;
		print_verdict();
	end

	initial begin
		seed = 6512;
		{cmd_valid_i, quad_command_mode_i, abort_i, wdata_valid_i} = 4'h0;
		{cmd_i, addr_i, len_i, param_byte_i, wdata_i} = '0;
		reset_i = 1'b1;
		repeat (8) @(posedge core_clk_i);
		#1 reset_i = 1'b0;
		`SFRP_CHK(burst_len_o, 8'h00)
		`SFRP_CHK(cont_mode_o, 1'b0)
		@(posedge core_clk_i);
		rd(SFRP_CMD_DUAL_RD, 24'h03_FFFE, 4, 8'h00, 1'b0, 0);
		rd(SFRP_CMD_QUAD_RD, rnd(), 3, 8'h00, 1'b0, 0);
		// Endless read cut by abort once three bytes are in; a fourth byte finds no note
		ws = rnd();
		for (int i = 0; i < 3; i++) exp_q.push_back(exp_at(24'(ws + i)));
		fork
			run(SFRP_CMD_QUAD_RD, 24'(ws), 16'h0000, 8'h00, 1'b0);
			begin
				while (exp_q.size() != 0) @(posedge core_clk_i);
				#1 abort_i = 1'b1;
			end
		join
		#1 abort_i = 1'b0;
		`SFRP_CHK({cs_n_o, dq_oe_o, 32'(exp_q.size())}, {1'b1, 4'h0, 32'd0})
		// Eight mode bytes; a kept mode makes the next frame start at the address
		foreach (modes[i]) begin
			rd(SFRP_CMD_QCONT_RD, rnd(), 2, modes[i], 1'b0, 0);
			`SFRP_CHK(cont_mode_o, modes[i][7:4] == ~modes[i][3:0])
		end
		rd(SFRP_CMD_QUAD_RD, rnd(), 2, 8'h00, 1'b0, 0);
		rd(SFRP_CMD_QCONT_RD, rnd(), 1, 8'h5A, 1'b0, 0);
		run(SFRP_CMD_CONT_EXIT, 24'h00_0000, 16'h0000, 8'h00, 1'b0);
		`SFRP_CHK(cont_mode_o, 1'b0)
		rd(SFRP_CMD_DUAL_RD, rnd(), 2, 8'h00, 1'b0, 0);
		// All burst codes; the upper two in quad command mode
		for (int c = 0; c < 4; c++) begin
			ws = 8 << c;
			run(SFRP_CMD_SET_BURST, 24'h00_0000, 16'h0000, 8'(c), c[1]);
			`SFRP_CHK(burst_len_o, 8'(c))
			rd(SFRP_CMD_BURST_RD, (rnd() & ~24'(ws - 1)) | 24'(ws - 2), ws + 3, 8'h00, c[1], ws);
		end
		run(4'h7, 24'h00_0000, 16'h0000, 8'h00, 1'b0); // write enable command code
		prog(24'h01_23FE, 3, 1'b1, 1'b0);
		rd(SFRP_CMD_QUAD_RD, 24'h01_23FE, 2, 8'h00, 1'b0, 0);
		rd(SFRP_CMD_QUAD_RD, 24'h01_2300, 1, 8'h00, 1'b0, 0);
		prog(24'h00_1000, 2, 1'b0, 1'b0); // latch already spent by the last cycle
		rd(SFRP_CMD_QUAD_RD, 24'h00_1000, 2, 8'h00, 1'b0, 0);
		run(4'h7, 24'h00_0000, 16'h0000, 8'h00, 1'b0);
		prog(24'h03_1000, 2, 1'b0, 1'b0);
		rd(SFRP_CMD_QUAD_RD, 24'h03_1000, 2, 8'h00, 1'b0, 0);
		run(4'h7, 24'h00_0000, 16'h0000, 8'h00, 1'b1);
		prog(24'h02_0000, 258, 1'b1, 1'b1);
		rd(SFRP_CMD_QUAD_RD, 24'h02_0000, 4, 8'h00, 1'b1, 0);
		print_verdict();
	end
endmodule : serial_flash_read_program_cmds_tb

`default_nettype wire
